// ---- design/dcbp_pkg.sv ----
// constants, types and register indices shared by the bus port files
`default_nettype none
package dcbp_pkg;
  localparam int          NCTL              = 2;
  localparam int          DATA_W            = 16;
  localparam int          CMD_W             = 8;
  localparam int          IDX_WR_BIT        = 7;
  localparam logic [6:0]  IDX_DMA_SETUP     = 7'h21;
  localparam logic [6:0]  IDX_XFER_COUNT    = 7'h22;
  localparam logic [6:0]  IDX_PART_ID       = 7'h27;
  localparam logic [6:0]  IDX_LONG_SCRATCH  = 7'h28;
  localparam logic [6:0]  IDX_FIFO          = 7'h40;
  localparam int          SETUP_CNT_SEL_BIT = 0;
  localparam int          SETUP_DMA_EN_BIT  = 1;
  localparam int          SETUP_DMA_RD_BIT  = 2;
  localparam logic [15:0] SETUP_RST         = 16'h0000;
  localparam logic [15:0] COUNT_RST         = 16'h0000;
  localparam logic [31:0] SCRATCH_RST       = 32'h0000_0000;
  localparam logic [15:0] WORDS_RST         = 16'h0000;
  localparam logic [7:0]  CMD_RST           = 8'h00;
  localparam logic [15:0] DATA_RST          = 16'h0000;
  // identity values are arbitrary
  localparam logic [15:0] HOST_PART_ID_VAL  = 16'h5A01;
  localparam logic [15:0] DEV_PART_ID_VAL   = 16'h5A02;
  localparam int          BUF_DEPTH         = 64;
  localparam int          BUF_AW            = 6;
  localparam logic [5:0]  BUF_PTR_RST       = 6'h00;
  typedef enum logic [1:0] {ST_IDLE, ST_REG, ST_FIFO_RD, ST_FIFO_WR} dcbp_acc_e;
endpackage
`default_nettype wire

// ---- design/dcbp_buf_if.sv ----
// buffer access signals between a controller's register logic and its buffer ram
`default_nettype none
interface dcbp_buf_if;
  logic        wr_en;
  logic        rd_en;
  logic        restart;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport ctl (output wr_en, output rd_en, output restart, output wdata, input rdata);
  modport mem (input wr_en, input rd_en, input restart, input wdata, output rdata);
endinterface
`default_nettype wire

// ---- design/dcbp_fbuf.sv ----
// fifo buffer ram of one controller, walked by a single pointer
`default_nettype none
module dcbp_fbuf (
  input wire logic mclk,
  input wire logic rst_n,
  dcbp_buf_if.mem  bus
);
  logic [15:0] mem_r [0:dcbp_pkg::BUF_DEPTH-1];
  logic [5:0]  ptr_r;
  logic [5:0]  ptr_nxt;

  // pointer wraps at the depth: more words than the depth overwrite the oldest words
  always_comb
  begin
    ptr_nxt = ptr_r;
    if (bus.restart)
      ptr_nxt = dcbp_pkg::BUF_PTR_RST;
    else if (bus.wr_en || bus.rd_en)
      ptr_nxt = ptr_r + 6'h01;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ptr_r <= dcbp_pkg::BUF_PTR_RST;
    else
      ptr_r <= ptr_nxt;
  end

  always_ff @(posedge mclk)
  begin
    if (bus.wr_en)
      mem_r[ptr_r] <= bus.wdata;
  end

  assign bus.rdata = mem_r[ptr_r];
endmodule
`default_nettype wire

// ---- design/dcbp_top.sv ----
// processor bus port: command and data ports, register file, fifo and dma paths
`default_nettype none
module dcbp_top (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        cs_n,
  input  wire logic        controller_select_line,
  input  wire logic        cmd_data_select_line,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic             data_oe_n,
  output logic             host_side_dma_request,
  input  wire logic        host_side_dma_grant_n,
  output logic             device_side_dma_request,
  input  wire logic        device_side_dma_grant_n,
  input  wire logic        transfer_end_input
);
  ////////////////////////////////////////////////////////////////////////////
  // strobe edges and port decode
  logic                            rd_prev_r;
  logic                            wr_prev_r;
  logic                            rd_prev_nxt;
  logic                            wr_prev_nxt;
  logic                            rd_start;
  logic                            wr_start;
  logic [dcbp_pkg::NCTL-1:0]       grant;
  logic [dcbp_pkg::NCTL-1:0]       sel_cmd;
  logic [dcbp_pkg::NCTL-1:0]       sel_dat;
  logic [dcbp_pkg::NCTL-1:0]       req_w;
  logic [15:0]                     rd_val [dcbp_pkg::NCTL];
  logic [15:0]                     data_out_r;
  logic [15:0]                     data_out_nxt;
  logic                            data_oe_n_r;
  logic                            data_oe_n_nxt;

  // a strobe acts once, on the first cycle it is seen low
  assign rd_start = !rd_n && rd_prev_r;
  assign wr_start = !wr_n && wr_prev_r;
  assign grant    = {!device_side_dma_grant_n, !host_side_dma_grant_n};

  ////////////////////////////////////////////////////////////////////////////
  // per-controller command decode, register file and fifo sequencing
  genvar c;
  generate
    for (c = 0; c < dcbp_pkg::NCTL; c++)
    begin : g_ctl
      logic                 line_hit;
      dcbp_pkg::dcbp_acc_e  st_r;
      dcbp_pkg::dcbp_acc_e  st_nxt;
      logic [7:0]           cmd_r;
      logic [7:0]           cmd_nxt;
      logic                 half_r;
      logic                 half_nxt;
      logic [15:0]          setup_r;
      logic [15:0]          setup_nxt;
      logic [15:0]          count_r;
      logic [15:0]          count_nxt;
      logic [31:0]          scratch_r;
      logic [31:0]          scratch_nxt;
      logic [15:0]          words_r;
      logic [15:0]          words_nxt;
      logic                 req_r;
      logic                 req_nxt;
      logic [15:0]          limit;
      logic [15:0]          part_id;
      dcbp_buf_if           bus ();

      assign line_hit = (c == 1) ? controller_select_line : !controller_select_line;
      // cs high leaves only the dma grant as a way in
      assign sel_cmd[c] = !cs_n && line_hit && cmd_data_select_line;
      assign sel_dat[c] = (!cs_n && line_hit && !cmd_data_select_line) || grant[c];
      assign limit      = {1'b0, count_r[15:1]};
      assign part_id    = (c == 0) ? dcbp_pkg::HOST_PART_ID_VAL : dcbp_pkg::DEV_PART_ID_VAL;
      assign req_w[c]   = req_r;

      always_comb
      begin
        st_nxt      = st_r;
        cmd_nxt     = cmd_r;
        half_nxt    = half_r;
        setup_nxt   = setup_r;
        count_nxt   = count_r;
        scratch_nxt = scratch_r;
        words_nxt   = words_r;
        rd_val[c]   = dcbp_pkg::DATA_RST;
        bus.wr_en   = 1'b0;
        bus.rd_en   = 1'b0;
        bus.restart = 1'b0;
        bus.wdata   = data_in;
        if (grant[c])
        begin
          // dma target: the grant stands in for address decode
          if (setup_r[dcbp_pkg::SETUP_DMA_EN_BIT])
          begin
            if (setup_r[dcbp_pkg::SETUP_DMA_RD_BIT] && rd_start)
            begin
              bus.rd_en = 1'b1;
              words_nxt = words_r + 16'h0001;
            end
            else if (!setup_r[dcbp_pkg::SETUP_DMA_RD_BIT] && wr_start)
            begin
              bus.wr_en = 1'b1;
              words_nxt = words_r + 16'h0001;
            end
          end
          rd_val[c] = bus.rdata;
        end
        else if (wr_start && sel_cmd[c])
        begin
          // upper byte is expected zero and is not looked at
          cmd_nxt  = data_in[7:0];
          half_nxt = 1'b0;
          if (data_in[6:0] == dcbp_pkg::IDX_FIFO)
          begin
            st_nxt      = data_in[dcbp_pkg::IDX_WR_BIT] ? dcbp_pkg::ST_FIFO_WR
                                                        : dcbp_pkg::ST_FIFO_RD;
            words_nxt   = dcbp_pkg::WORDS_RST;
            bus.restart = 1'b1;
          end
          else
            st_nxt = dcbp_pkg::ST_REG;
        end
        else if (sel_dat[c] && (wr_start || rd_start))
        begin
          case (st_r)
            dcbp_pkg::ST_REG:
            begin
              // write needs bit 7 set, read needs it clear
              if (wr_start && cmd_r[dcbp_pkg::IDX_WR_BIT])
              begin
                case (cmd_r[6:0])
                  dcbp_pkg::IDX_DMA_SETUP:
                  begin
                    setup_nxt = data_in;
                    if (data_in[dcbp_pkg::SETUP_DMA_EN_BIT])
                    begin
                      words_nxt   = dcbp_pkg::WORDS_RST;
                      bus.restart = 1'b1;
                    end
                  end
                  dcbp_pkg::IDX_XFER_COUNT: count_nxt = data_in;
                  dcbp_pkg::IDX_LONG_SCRATCH:
                  begin
                    if (!half_r)
                      scratch_nxt[15:0] = data_in;
                    else
                      scratch_nxt[31:16] = data_in;
                    half_nxt = !half_r;
                  end
                  default: ;
                endcase
              end
              else if (rd_start && !cmd_r[dcbp_pkg::IDX_WR_BIT])
              begin
                case (cmd_r[6:0])
                  dcbp_pkg::IDX_DMA_SETUP:  rd_val[c] = setup_r;
                  dcbp_pkg::IDX_XFER_COUNT: rd_val[c] = count_r;
                  dcbp_pkg::IDX_PART_ID:    rd_val[c] = part_id;
                  dcbp_pkg::IDX_LONG_SCRATCH:
                  begin
                    rd_val[c] = half_r ? scratch_r[31:16] : scratch_r[15:0];
                    half_nxt  = !half_r;
                  end
                  default: rd_val[c] = dcbp_pkg::DATA_RST;
                endcase
              end
            end
            dcbp_pkg::ST_FIFO_WR:
            begin
              // strobes of the other direction are dropped
              if (wr_start && (words_r < limit))
              begin
                bus.wr_en = 1'b1;
                words_nxt = words_r + 16'h0001;
              end
            end
            dcbp_pkg::ST_FIFO_RD:
            begin
              // the word at the pointer goes out, then the pointer moves on
              if (rd_start && (words_r < limit))
              begin
                bus.rd_en = 1'b1;
                rd_val[c] = bus.rdata;
                words_nxt = words_r + 16'h0001;
              end
            end
            default: ;
          endcase
          // idle with the last word, so surplus strobes cannot move the pointer
          if (((st_r == dcbp_pkg::ST_FIFO_WR) || (st_r == dcbp_pkg::ST_FIFO_RD))
              && (words_nxt >= limit))
            st_nxt = dcbp_pkg::ST_IDLE;
        end
        // both ends clear the enable; an end wins over a same-cycle restart
        if (setup_r[dcbp_pkg::SETUP_DMA_EN_BIT] && transfer_end_input)
          setup_nxt[dcbp_pkg::SETUP_DMA_EN_BIT] = 1'b0;
        if (setup_r[dcbp_pkg::SETUP_DMA_EN_BIT] && setup_r[dcbp_pkg::SETUP_CNT_SEL_BIT]
            && grant[c] && (words_nxt >= limit))
          setup_nxt[dcbp_pkg::SETUP_DMA_EN_BIT] = 1'b0;
        // a level for the whole enabled period; a burst master simply follows it
        req_nxt = setup_nxt[dcbp_pkg::SETUP_DMA_EN_BIT];
      end

      // buffer words are not reset, only pointer, registers, counters and state
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
        begin
          st_r      <= dcbp_pkg::ST_IDLE;
          cmd_r     <= dcbp_pkg::CMD_RST;
          half_r    <= 1'b0;
          setup_r   <= dcbp_pkg::SETUP_RST;
          count_r   <= dcbp_pkg::COUNT_RST;
          scratch_r <= dcbp_pkg::SCRATCH_RST;
          words_r   <= dcbp_pkg::WORDS_RST;
          req_r     <= 1'b0;
        end
        else
        begin
          st_r      <= st_nxt;
          cmd_r     <= cmd_nxt;
          half_r    <= half_nxt;
          setup_r   <= setup_nxt;
          count_r   <= count_nxt;
          scratch_r <= scratch_nxt;
          words_r   <= words_nxt;
          req_r     <= req_nxt;
        end
      end

      dcbp_fbuf u_fbuf (
        .mclk  (mclk),
        .rst_n (rst_n),
        .bus   (bus.mem)
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // output data register and drive enable
  // data_out holds the last read word until the next read strobe on a selected data port or under a grant starts
  always_comb
  begin
    rd_prev_nxt  = rd_n;
    wr_prev_nxt  = wr_n;
    data_out_nxt = data_out_r;
    for (int k = 0; k < dcbp_pkg::NCTL; k++)
    begin
      if (rd_start && sel_dat[k])
        data_out_nxt = rd_val[k];
    end
    // driven only while a selected data port or a grant sees read low
    data_oe_n_nxt = !(!rd_n && (|sel_dat));
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      // history high: a strobe already low at release acts once
      rd_prev_r   <= 1'b1;
      wr_prev_r   <= 1'b1;
      data_out_r  <= dcbp_pkg::DATA_RST;
      data_oe_n_r <= 1'b1;
    end
    else
    begin
      rd_prev_r   <= rd_prev_nxt;
      wr_prev_r   <= wr_prev_nxt;
      data_out_r  <= data_out_nxt;
      data_oe_n_r <= data_oe_n_nxt;
    end
  end

  assign data_out                = data_out_r;
  assign data_oe_n               = data_oe_n_r;
  assign host_side_dma_request   = req_w[0];
  assign device_side_dma_request = req_w[1];
endmodule
`default_nettype wire

// ---- sim/dcbp_top_properties.sv ----
// concurrent checks on the processor bus port pins
`default_nettype none
module dcbp_top_properties (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        cs_n,
  input wire logic        controller_select_line,
  input wire logic        cmd_data_select_line,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic        data_oe_n,
  input wire logic        host_side_dma_request,
  input wire logic        host_side_dma_grant_n,
  input wire logic        device_side_dma_request,
  input wire logic        device_side_dma_grant_n,
  input wire logic        transfer_end_input
);
  logic       rd_q_r, rd_q_nxt, wr_q_r, wr_q_nxt, nog, hsel, rgo, wgo;
  logic [7:0] hcmd_r, hcmd_nxt;
  assign nog = host_side_dma_grant_n && device_side_dma_grant_n;
  assign hsel = !cs_n && !controller_select_line && nog;
  assign rgo = !rd_n && rd_q_r;
  assign wgo = !wr_n && wr_q_r;
  // last host command, cleared by a data phase so only the first read counts
  always_comb
  begin
    rd_q_nxt = rd_n;
    wr_q_nxt = wr_n;
    hcmd_nxt = hcmd_r;
    if (hsel && wgo && cmd_data_select_line)
      hcmd_nxt = data_in[7:0];
    else if (hsel && (rgo || wgo) && !cmd_data_select_line)
      hcmd_nxt = 8'h00;
  end
  always_ff @(posedge mclk)
  begin
    rd_q_r <= rst_n ? rd_q_nxt : 1'h1;
    wr_q_r <= rst_n ? wr_q_nxt : 1'h1;
    hcmd_r <= rst_n ? hcmd_nxt : 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_reset_quiet: assert property ($rose(rst_n) |-> data_oe_n && !host_side_dma_request
    && !device_side_dma_request) else $error("outputs active right after reset");
  a_idle_undriven: assert property ((cs_n && nog) [*2] |-> data_oe_n)
    else $error("bus driven while deselected");
  a_read_drives: assert property (rgo && !cs_n && !cmd_data_select_line |=> !data_oe_n)
    else $error("data port read not driven");
  a_cmd_undriven: assert property ((!cs_n && cmd_data_select_line && nog) [*2]
    |-> data_oe_n) else $error("command port driven");
  a_id_value: assert property (rgo && hsel && !cmd_data_select_line && hcmd_r == 8'h27
    |=> data_out == dcbp_pkg::HOST_PART_ID_VAL) else $error("identity read wrong");
  a_req_rises: assert property (wgo && hsel && !cmd_data_select_line && hcmd_r == 8'hA1
    && data_in[1] && !transfer_end_input |-> ##[1:2] host_side_dma_request)
    else $error("host request not raised");
  a_end_drops: assert property ((host_side_dma_request || device_side_dma_request)
    && transfer_end_input |-> ##[1:2] !(host_side_dma_request || device_side_dma_request))
    else $error("request survived end of transfer");
  // a host data write may clear the enable on purpose, so it is left out
  a_req_holds: assert property (host_side_dma_request && !transfer_end_input
    && host_side_dma_grant_n && !(wgo && hsel && !cmd_data_select_line)
    |=> host_side_dma_request) else $error("host request dropped");
  c_id_read: cover property (rgo && hsel && hcmd_r == 8'h27);
  c_host_end: cover property ($fell(host_side_dma_request));
  c_dev_end: cover property ($fell(device_side_dma_request));
endmodule
bind dcbp_top dcbp_top_properties dcbp_top_properties_i (.mclk, .rst_n, .cs_n,
  .controller_select_line, .cmd_data_select_line, .rd_n, .wr_n, .data_in, .data_out,
  .data_oe_n, .host_side_dma_request, .host_side_dma_grant_n, .device_side_dma_request,
  .device_side_dma_grant_n, .transfer_end_input);
`default_nettype wire

// ---- sim/dcbp_dma_master.sv ----
// system dma controller model: grants a request and moves words one by one
`default_nettype none
module dcbp_dma_master #(
  parameter int GAP = 0
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic        rd_mode,
  input  wire logic [15:0] rdata,
  output logic             grant_n,
  output logic             wr_n,
  output logic             rd_n,
  output logic      [15:0] wdata,
  output logic      [15:0] rword
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap_cnt;
  initial
  begin
    grant_n = 1'h1;
    wr_n = 1'h1;
    rd_n = 1'h1;
    wdata = 16'hD000;
    rword = 16'h0000;
    gap_cnt = 0;
  end
  // rd_mode fixes one direction per enabled period; GAP makes a slow master
  always @(negedge mclk)
  begin
    if (!rd_n)
      rword <= rdata;
    if (!rst_n || !req)
    begin
      grant_n <= 1'h1;
      wr_n <= 1'h1;
      rd_n <= 1'h1;
    end
    else if (grant_n)
      grant_n <= 1'h0;
    else if (!wr_n || !rd_n)
    begin
      if (!wr_n)
        wdata <= wdata + 16'h0001;
      wr_n <= 1'h1;
      rd_n <= 1'h1;
      gap_cnt <= GAP;
    end
    else if (gap_cnt > 0)
      gap_cnt <= gap_cnt - 1;
    else if (rd_mode)
      rd_n <= 1'h0;
    else
      wr_n <= 1'h0;
  end
endmodule
`default_nettype wire

// ---- sim/dcbp_top_bench.sv ----
// self-checking bench for the processor bus port
`default_nettype none
module dcbp_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, cs_n, controller_select_line, cmd_data_select_line, w1, w2;
  logic        rd_n, b_wr_n, transfer_end_input, data_oe_n, host_side_dma_request;
  logic        device_side_dma_request, host_side_dma_grant_n, device_side_dma_grant_n;
  logic        r1, r2, m_rd;
  logic [15:0] b_data, data_out, d1, d2, q1;
  int          n_mismatch, total_checks, i;
  wire logic        wr_n = b_wr_n & w1 & w2;
  wire logic        rd_in = rd_n & r1 & r2;
  wire logic [15:0] data_in = !host_side_dma_grant_n ? d1
                              : (!device_side_dma_grant_n ? d2 : b_data);
  dcbp_top dcbp_top_i (.mclk, .rst_n, .cs_n, .controller_select_line, .cmd_data_select_line,
    .rd_n(rd_in), .wr_n, .data_in, .data_out, .data_oe_n, .host_side_dma_request,
    .host_side_dma_grant_n, .device_side_dma_request, .device_side_dma_grant_n,
    .transfer_end_input);
  dcbp_dma_master #(.GAP(0)) dcbp_dma_master_i (.mclk, .rst_n, .req(host_side_dma_request),
    .rd_mode(m_rd), .rdata(data_out), .grant_n(host_side_dma_grant_n), .wr_n(w1), .rd_n(r1),
    .wdata(d1), .rword(q1));
  dcbp_dma_master #(.GAP(3)) dcbp_dma_master_dev_i (.mclk, .rst_n,
    .req(device_side_dma_request), .rd_mode(1'h0), .rdata(data_out),
    .grant_n(device_side_dma_grant_n), .wr_n(w2), .rd_n(r2), .wdata(d2), .rword());
  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe low cycle; bus value inverted afterwards so stale data never matches
  task automatic put(input logic c, input logic a0, input logic [15:0] v);
    @(negedge mclk);
    cs_n = 1'h0;
    controller_select_line = c;
    cmd_data_select_line = a0;
    b_data = v;
    b_wr_n = 1'h0;
    @(negedge mclk);
    b_wr_n = 1'h1;
    cs_n = 1'h1;
    b_data = ~v;
  endtask
  task automatic get(input logic c, input logic [15:0] exp);
    @(negedge mclk);
    cs_n = 1'h0;
    controller_select_line = c;
    cmd_data_select_line = 1'h0;
    rd_n = 1'h0;
    repeat (2) @(negedge mclk);
    chk(data_out, exp);
    chk({15'h0000, data_oe_n}, 16'h0000);
    rd_n = 1'h1;
    cs_n = 1'h1;
  endtask
  task automatic wait_req(input logic c, input logic lvl);
    for (int k = 0; k < 60 && (c ? device_side_dma_request : host_side_dma_request) !== lvl; k++)
      @(negedge mclk);
    chk({15'h0000, c ? device_side_dma_request : host_side_dma_request}, {15'h0000, lvl});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  // the whole sequence needs well under 2000 cycles
  initial
  begin
    #100000;
    n_mismatch++;
    complete_run();
  end
  initial
  begin
    {rst_n, transfer_end_input, m_rd} = 3'h0;
    {cs_n, rd_n, b_wr_n, controller_select_line, cmd_data_select_line} = 5'h1C;
    b_data = 16'h0000;
    n_mismatch = 0;
    total_checks = 0;
    repeat (12) @(negedge mclk);
    rst_n = 1'h1;
    chk({15'h0000, data_oe_n}, 16'h0001);
    put(0, 1, 16'h0027);
    get(0, dcbp_pkg::HOST_PART_ID_VAL);
    put(1, 1, 16'h0027);
    get(1, dcbp_pkg::DEV_PART_ID_VAL);
    $display("test identity done");
    put(0, 1, 16'h00A2);
    put(0, 0, 16'h0006);
    put(0, 1, 16'h0022);
    get(0, 16'h0006);
    put(0, 1, 16'h00A2);
    get(0, 16'h0000);
    put(0, 1, 16'h0033);
    get(0, 16'h0000);
    put(0, 1, 16'h00A8);
    put(0, 0, 16'h1111);
    put(0, 0, 16'h2222);
    put(0, 1, 16'h0028);
    get(0, 16'h1111);
    get(0, 16'h2222);
    $display("test registers done");
    put(0, 1, 16'h00C0);
    for (i = 0; i < 4; i++)
      put(0, 0, 16'hB000 + 16'(i));
    put(0, 1, 16'h0040);
    for (i = 0; i < 3; i++)
      get(0, 16'hB000 + 16'(i));
    get(0, 16'h0000);
    @(negedge mclk);
    rd_n = 1'h0;
    repeat (3) @(negedge mclk);
    chk({15'h0000, data_oe_n}, 16'h0001);
    rd_n = 1'h1;
    $display("test fifo done");
    put(0, 1, 16'h00A2);
    put(0, 0, 16'h0004);
    put(0, 1, 16'h00A1);
    put(0, 0, 16'h0003);
    wait_req(0, 1);
    wait_req(0, 0);
    repeat (2) @(negedge mclk);
    put(0, 1, 16'h0021);
    get(0, 16'h0001);
    put(0, 1, 16'h0040);
    get(0, 16'hD000);
    get(0, 16'hD001);
    m_rd = 1'h1;
    put(0, 1, 16'h00A1);
    put(0, 0, 16'h0007);
    wait_req(0, 1);
    wait_req(0, 0);
    repeat (2) @(negedge mclk);
    chk(q1, 16'hD001);
    m_rd = 1'h0;
    put(0, 1, 16'h0021);
    get(0, 16'h0005);
    $display("test host dma done");
    put(1, 1, 16'h00A1);
    put(1, 0, 16'h0002);
    wait_req(1, 1);
    repeat (12) @(negedge mclk);
    chk({15'h0000, device_side_dma_request}, 16'h0001);
    transfer_end_input = 1'h1;
    wait_req(1, 0);
    transfer_end_input = 1'h0;
    repeat (2) @(negedge mclk);
    put(1, 1, 16'h0021);
    get(1, 16'h0000);
    $display("test device dma done");
    complete_run();
  end
endmodule
`default_nettype wire
